// ---- verification/otpa_top_tb.sv ----
`timescale 1ns/1ns
module otpa_top_tb;
    import otpa_pkg::*;
    logic      i_ref_clk = 1'b0;
    logic      i_rstn    = 1'b0;
    otpa_req_s i_prog    = '0;
    logic      i_rd_en   = 1'b0;
    logic [9:0] i_rd_addr = 10'h000;
    logic      o_ready;
    logic      o_prog_busy;
    otpa_rsp_s o_rd;
    logic [7:0] mem_q [OTPA_DEPTH];
    int        fail_count = 0;
    int        num_checks = 0;
    int        a;

    otpa_top dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_prog(i_prog),
        .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .o_ready(o_ready),
        .o_prog_busy(o_prog_busy), .o_rd(o_rd));

    always #2 i_ref_clk = ~i_ref_clk;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] fuse_or(input logic [7:0] old, input logic [7:0] d);
        return old | d;
    endfunction

    task automatic final_report;
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic do_reset;
        int n;
        @(negedge i_ref_clk);
        i_rstn = 1'b0;
        repeat (10) @(negedge i_ref_clk);
        chk("ready_rst", 8'h00, {7'h00, o_ready});
        i_rstn = 1'b1;
        foreach (mem_q[k]) mem_q[k] = OTPA_BLANK;
        // Early request while clearing must be dropped
        i_prog = '{valid: 1'b1, bulk: 1'b0, addr: 10'h005, data: 8'hFF};
        repeat (4) @(negedge i_ref_clk);
        i_prog.valid = 1'b0;
        n = 0;
        while (o_ready !== 1'b1 && n < 900) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("ready", 8'h01, {7'h00, o_ready});
    endtask

    task automatic rd(input logic [9:0] ra);
        i_rd_en = 1'b1;
        i_rd_addr = ra;
        @(negedge i_ref_clk);
        i_rd_en = 1'b0;
        @(negedge i_ref_clk);
        chk("rd_valid", 8'h01, {7'h00, o_rd.valid});
        chk("rd_data", mem_q[ra], o_rd.data);
    endtask

    task automatic pr(input logic bulk, input logic [9:0] pa, input logic [7:0] d);
        int n;
        logic take;
        take = bulk || pa <= OTPA_LAST_ADDR;
        i_prog = '{valid: 1'b1, bulk: bulk, addr: pa, data: d};
        @(negedge i_ref_clk);
        chk("busy", {7'h00, take}, {7'h00, o_prog_busy});
        // Poke while busy; refused, so the model ignores it
        i_prog = '{valid: take, bulk: 1'b0, addr: pa ^ 10'h001, data: 8'hFF};
        @(negedge i_ref_clk);
        i_prog.valid = 1'b0;
        n = 0;
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (o_prog_busy !== 1'b0 && n < 2000);
        chk("busy_end", 8'h00, {7'h00, o_prog_busy});
        if (bulk) foreach (mem_q[k]) mem_q[k] = fuse_or(mem_q[k], d);
        else if (take) mem_q[pa] = fuse_or(mem_q[pa], d);
    endtask

    initial begin
        #(4 * 60000);
        fail_count++;
        final_report();
    end

    initial begin
        void'($urandom(32'h020D2541));
        do_reset();
        rd(OTPA_ADDR_ZERO);
        rd(OTPA_LAST_ADDR);
        pr(1'b0, OTPA_ADDR_ZERO, 8'hA5);
        pr(1'b0, OTPA_ADDR_ZERO, 8'h5A);
        pr(1'b0, OTPA_ADDR_ZERO, 8'h00);
        pr(1'b0, OTPA_LAST_ADDR, 8'h81);
        pr(1'b0, 10'h300, 8'hFF);
        rd(OTPA_ADDR_ZERO);
        rd(OTPA_LAST_ADDR);
        for (int i = 0; i < 40; i++) begin
            a = $urandom_range(767);
            pr(1'b0, a[9:0], 8'($urandom));
            rd(a[9:0]);
        end
        pr(1'b1, OTPA_ADDR_ZERO, 8'h12);
        pr(1'b1, OTPA_ADDR_ZERO, 8'h40);
        // Full sweep covers every byte of the array
        for (int i = 0; i < OTPA_DEPTH; i++) rd(i[9:0]);
        do_reset();
        rd(10'h005);
        final_report();
    end
endmodule

// ---- verilog/otpa_mem.sv ----
`timescale 1ns/1ns
module otpa_mem (
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_we,
    input  wire logic [otpa_pkg::OTPA_AW-1:0] i_waddr,
    input  wire logic [otpa_pkg::OTPA_DW-1:0] i_wdata,
    input  wire logic [otpa_pkg::OTPA_AW-1:0] i_raddr,
    output logic      [otpa_pkg::OTPA_DW-1:0] o_rdata
);
    import otpa_pkg::*;

    logic [OTPA_DW-1:0] mem [OTPA_DEPTH];

    // Registered read; no reset so it maps onto a memory macro
    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// ---- verilog/otpa_pkg.sv ----
package otpa_pkg;
    localparam int OTPA_BITS      = 6144;
    localparam int OTPA_DEPTH     = 768;
    localparam int OTPA_AW        = 10;
    localparam int OTPA_DW        = 8;
    localparam logic [9:0] OTPA_LAST_ADDR = 10'h2FF;
    localparam logic [7:0] OTPA_BLANK     = 8'h00;
    localparam logic [9:0] OTPA_ADDR_ZERO = 10'h000;

    typedef enum logic [1:0] {
        OTPA_ST_CLEAR,
        OTPA_ST_IDLE,
        OTPA_ST_BULK
    } otpa_state_e;

    typedef struct packed {
        logic                valid;
        logic                bulk;
        logic [OTPA_AW-1:0]  addr;
        logic [OTPA_DW-1:0]  data;
    } otpa_req_s;

    typedef struct packed {
        logic                valid;
        logic [OTPA_DW-1:0]  data;
    } otpa_rsp_s;
endpackage

// ---- verilog/otpa_top.sv ----
`timescale 1ns/1ns
module otpa_top (
    input  wire logic                i_ref_clk,
    input  wire logic                i_rstn,
    input  wire otpa_pkg::otpa_req_s i_prog,
    input  wire logic                i_rd_en,
    input  wire logic [9:0]          i_rd_addr,
    output logic                     o_ready,
    output logic                     o_prog_busy,
    output otpa_pkg::otpa_rsp_s      o_rd
);
    import otpa_pkg::*;

    typedef struct packed {
        otpa_state_e          state;
        logic [OTPA_AW-1:0]   ptr;
        logic                 pend;
        logic [OTPA_AW-1:0]   paddr;
        logic [OTPA_DW-1:0]   pdata;
        logic                 bulk;
        logic [OTPA_DW-1:0]   bdata;
        logic                 rd_pipe;
        logic                 ready;
        logic                 busy;
        otpa_rsp_s            rsp;
    } otpa_regs_s;

    otpa_regs_s r_q;
    otpa_regs_s r_d;

    logic               mem_we;
    logic [OTPA_AW-1:0] mem_waddr;
    logic [OTPA_DW-1:0] mem_wdata;
    logic [OTPA_AW-1:0] mem_raddr;
    logic [OTPA_DW-1:0] mem_rdata;

    // Read-modify-write: OR into old contents so programming can never clear a one
    otpa_mem u_mem (
        .i_ref_clk (i_ref_clk),
        .i_we      (mem_we),
        .i_waddr   (mem_waddr),
        .i_wdata   (mem_wdata),
        .i_raddr   (mem_raddr),
        .o_rdata   (mem_rdata)
    );

    always_comb begin
        r_d          = r_q;
        mem_we       = 1'b0;
        mem_waddr    = r_q.ptr;
        mem_wdata    = OTPA_BLANK;
        mem_raddr    = i_rd_addr;
        r_d.rsp.valid = 1'b0;
        r_d.rd_pipe  = 1'b0;
        case (r_q.state)
            OTPA_ST_CLEAR: begin
                // Models blank fuses at power-up
                mem_we    = 1'b1;
                mem_wdata = OTPA_BLANK;
                r_d.ptr   = r_q.ptr + 10'h001;
                if (r_q.ptr == OTPA_LAST_ADDR) begin
                    r_d.state = OTPA_ST_IDLE;
                    r_d.ptr   = OTPA_ADDR_ZERO;
                    r_d.ready = 1'b1;
                end
            end
            OTPA_ST_IDLE: begin
                if (r_q.pend) begin
                    mem_we    = 1'b1;
                    mem_waddr = r_q.paddr;
                    mem_wdata = mem_rdata | r_q.pdata;
                    r_d.pend  = 1'b0;
                    r_d.busy  = 1'b0;
                end else if (i_prog.valid && i_prog.bulk) begin
                    r_d.state = OTPA_ST_BULK;
                    r_d.bdata = i_prog.data;
                    r_d.ptr   = OTPA_ADDR_ZERO;
                    r_d.busy  = 1'b1;
                    r_d.bulk  = 1'b1;
                    mem_raddr = OTPA_ADDR_ZERO;
                end else if (i_prog.valid && (i_prog.addr <= OTPA_LAST_ADDR)) begin
                    r_d.pend  = 1'b1;
                    r_d.paddr = i_prog.addr;
                    r_d.pdata = i_prog.data;
                    r_d.busy  = 1'b1;
                    mem_raddr = i_prog.addr;
                end else if (i_rd_en) begin
                    r_d.rd_pipe = 1'b1;
                end
            end
            OTPA_ST_BULK: begin
                // Even cycles fetch, odd cycles write back with OR
                if (!r_q.pend) begin
                    mem_raddr = r_q.ptr;
                    r_d.pend  = 1'b1;
                end else begin
                    mem_we    = 1'b1;
                    mem_waddr = r_q.ptr;
                    mem_wdata = mem_rdata | r_q.bdata;
                    r_d.pend  = 1'b0;
                    r_d.ptr   = r_q.ptr + 10'h001;
                    if (r_q.ptr == OTPA_LAST_ADDR) begin
                        r_d.state = OTPA_ST_IDLE;
                        r_d.busy  = 1'b0;
                        r_d.bulk  = 1'b0;
                        r_d.ptr   = OTPA_ADDR_ZERO;
                    end
                end
            end
            default: begin
                r_d.state = OTPA_ST_CLEAR;
            end
        endcase
        if (r_q.rd_pipe) begin
            r_d.rsp.valid = 1'b1;
            r_d.rsp.data  = mem_rdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_ready     = r_q.ready;
    assign o_prog_busy = r_q.busy;
    assign o_rd        = r_q.rsp;

    // Watch the last byte programmed; its ones come from the requests, not the array
    localparam int CLEAR_LAST = OTPA_DEPTH - 1;
    localparam int BULK_LAST  = 2 * OTPA_DEPTH - 1;

    logic               shd_vld;
    logic [OTPA_AW-1:0] shd_addr;
    logic [OTPA_DW-1:0] shd_ones;
    logic [10:0]        st_cnt;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            shd_vld  <= 1'b0;
            shd_addr <= OTPA_ADDR_ZERO;
            shd_ones <= OTPA_BLANK;
        end else if (r_q.state == OTPA_ST_IDLE && r_q.pend) begin
            shd_vld  <= 1'b1;
            shd_addr <= r_q.paddr;
            shd_ones <= (shd_vld && r_q.paddr == shd_addr) ?
                        (shd_ones | r_q.pdata) : r_q.pdata;
        end else if (r_q.state == OTPA_ST_BULK && mem_we) begin
            if (shd_vld && mem_waddr == shd_addr) begin
                shd_ones <= shd_ones | r_q.bdata;
            end
        end
    end

    // Cycles spent in the current state; wraps harmlessly while idle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || r_d.state != r_q.state) begin
            st_cnt <= 11'h000;
        end else begin
            st_cnt <= st_cnt + 11'h001;
        end
    end

    sequence s_rd_req;
        r_q.state == OTPA_ST_IDLE && !r_q.pend && !i_prog.valid && i_rd_en;
    endsequence

    sequence s_watch_rd;
        r_q.state == OTPA_ST_IDLE && !r_q.pend && !i_prog.valid && i_rd_en
        && shd_vld && i_rd_addr == shd_addr;
    endsequence

    sequence s_byte_take;
        r_q.state == OTPA_ST_IDLE && !r_q.pend && i_prog.valid && !i_prog.bulk
        && i_prog.addr <= OTPA_LAST_ADDR;
    endsequence

    sequence s_bulk_take;
        r_q.state == OTPA_ST_IDLE && !r_q.pend && i_prog.valid && i_prog.bulk;
    endsequence

    sequence s_busy_pulse;
        o_prog_busy ##1 !o_prog_busy;
    endsequence

    chk_read_latency: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_rd_req |-> ##2 o_rd.valid)
        else $error("read answer not two cycles after request");

    chk_no_read_early: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !o_ready |-> !o_rd.valid)
        else $error("read answered before array ready");

    chk_ready_sticks: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_ready |=> o_ready)
        else $error("ready dropped");

    chk_clear_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (r_q.state == OTPA_ST_CLEAR && mem_we) |-> mem_wdata == OTPA_BLANK)
        else $error("clear wrote nonzero");

    chk_or_keeps_ones: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (mem_we && r_q.state != OTPA_ST_CLEAR) |-> ((mem_wdata & mem_rdata) == mem_rdata))
        else $error("programmed one cleared");

    chk_byte_or: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (r_q.state == OTPA_ST_IDLE && r_q.pend) |-> mem_wdata == (mem_rdata | r_q.pdata))
        else $error("byte program not OR of old and new");

    chk_byte_done: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_byte_take |=> s_busy_pulse)
        else $error("byte program not two cycles");

    chk_bulk_start: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_bulk_take |=> r_q.state == OTPA_ST_BULK && r_q.ptr == OTPA_ADDR_ZERO)
        else $error("bulk program did not start");

    chk_addr_range: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        mem_we |-> mem_waddr <= OTPA_LAST_ADDR)
        else $error("write outside array");

    chk_ones_kept: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_watch_rd |-> ##2 ((o_rd.data & shd_ones) == shd_ones))
        else $error("programmed one lost on read back");

    chk_watch_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (mem_we && r_q.state != OTPA_ST_CLEAR && shd_vld && mem_waddr == shd_addr)
        |-> ((mem_wdata & shd_ones) == shd_ones))
        else $error("rewrite dropped a programmed one");

    chk_clear_len: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(o_ready) |-> $past(st_cnt) == CLEAR_LAST)
        else $error("blanking did not take one cycle per byte");

    chk_bulk_len: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ($past(r_q.state) == OTPA_ST_BULK && r_q.state == OTPA_ST_IDLE)
        |-> $past(st_cnt) == BULK_LAST)
        else $error("bulk program length wrong");

    chk_bulk_busy: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        r_q.state == OTPA_ST_BULK |-> o_prog_busy && st_cnt <= BULK_LAST)
        else $error("bulk run not busy or overran");
endmodule
